// ===== tmr_defs.svh
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ----------------------------------------------------------------
// control register field positions and reset value
// ----------------------------------------------------------------
`define TMR_CTRL_EN_BIT      7
`define TMR_CTRL_WIDTH8_BIT  6
`define TMR_CTRL_SRC_BIT     5
`define TMR_CTRL_EDGE_BIT    4
`define TMR_CTRL_BYPASS_BIT  3
`define TMR_CTRL_PS_MSB      2
`define TMR_CTRL_PS_LSB      0
`define TMR_CTRL_RESET       8'h08

// ----------------------------------------------------------------
// data reset values and timing counts
// ----------------------------------------------------------------
`define TMR_BYTE_RESET       8'h00
`define TMR_BYTE_MAX         8'hff
`define TMR_WR_INHIBIT       2'h2
`define TMR_SYNC_STAGES      2

`endif

// ===== tmr_pkg.sv
`default_nettype none

package tmr_pkg;

	typedef logic [7:0] tmr_byte_t;

	typedef enum logic {
		TMR_SRC_CLK,
		TMR_SRC_PIN
	} tmr_src_t;

endpackage : tmr_pkg

`default_nettype wire

// ===== tmr_sync.sv
`default_nettype none

module tmr_sync (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic d,
	output var  logic q
);

	logic stage1;

	// first stage is read by the second stage only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			q      <= 1'b0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end

endmodule : tmr_sync

`default_nettype wire

// ===== tmr_counter.sv
`include "tmr_defs.svh"
`default_nettype none

module tmr_counter #(
	parameter int PS_W = 8
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             external_count_input,
	input  wire logic             ctrl_wr,
	input  wire logic             ctrl_rd,
	input  wire logic             low_wr,
	input  wire logic             low_rd,
	input  wire logic             high_wr,
	input  wire logic             high_rd,
	input  wire logic [7:0]       wdata,
	input  wire logic             flag_clr,
	output var  logic [7:0]       rdata,
	output var  logic [7:0]       timer_control_register,
	output var  logic [7:0]       counter_low_byte,
	output var  logic [7:0]       upper_byte_buffer,
	output var  logic             overflow_flag
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tmr_pkg::tmr_byte_t true_high;
	logic [PS_W-1:0]    pre_cnt;
	logic [1:0]         inhibit;
	logic               ext_sync;
	logic               ext_prev;

	tmr_sync u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    (external_count_input),
		.q    (ext_sync)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	tmr_pkg::tmr_src_t src;
	wire logic        en;
	wire logic        mode8;
	wire logic        edge_fall;
	wire logic        bypass;
	wire logic [2:0]  ps_sel;
	wire logic [PS_W-1:0] pre_mask;
	wire logic        ext_event;
	wire logic        tick;
	wire logic        pre_hit;
	wire logic        inc;
	wire logic        low_max;
	wire logic        wrap;
	wire logic [7:0]  next_low;
	wire logic [7:0]  next_high;
	wire logic [7:0]  next_buf;
	wire logic [7:0]  next_rdata;

	assign src       = tmr_pkg::tmr_src_t'(
		timer_control_register[`TMR_CTRL_SRC_BIT]);
	assign en        = timer_control_register[`TMR_CTRL_EN_BIT];
	assign mode8     = timer_control_register[`TMR_CTRL_WIDTH8_BIT];
	assign edge_fall = timer_control_register[`TMR_CTRL_EDGE_BIT];
	assign bypass    = timer_control_register[`TMR_CTRL_BYPASS_BIT];
	assign ps_sel    = timer_control_register[`TMR_CTRL_PS_MSB:
		`TMR_CTRL_PS_LSB];
	// ratio is two to the power of ps_sel plus one
	assign pre_mask  = PS_W'((32'h2 << ps_sel) - 32'h1);
	// edge taken after the synchroniser, so the count lags the pin
	assign ext_event = edge_fall ? (ext_prev & ~ext_sync)
		: (ext_sync & ~ext_prev);
	assign tick      = (src == tmr_pkg::TMR_SRC_PIN) ? ext_event
		: 1'b1;
	assign pre_hit   = bypass | (pre_cnt == pre_mask);
	// a write owns the cycle; its value must not be bumped at once
	assign inc       = en & tick & pre_hit & (inhibit == 2'h0)
		& ~low_wr;
	assign low_max   = counter_low_byte == `TMR_BYTE_MAX;
	assign wrap      = inc & low_max
		& (mode8 | (true_high == `TMR_BYTE_MAX));
	assign next_low  = low_wr ? wdata
		: inc ? counter_low_byte + 8'h01 : counter_low_byte;
	// high byte only through the buffer, and idle in 8-bit mode
	assign next_high = (low_wr & ~mode8) ? upper_byte_buffer
		: (inc & low_max & ~mode8) ? true_high + 8'h01
		: true_high;
	assign next_buf  = high_wr ? wdata
		: low_rd ? true_high : upper_byte_buffer;
	assign next_rdata = low_rd ? counter_low_byte
		: high_rd ? upper_byte_buffer
		: ctrl_rd ? timer_control_register : 8'h00;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_control_register <= `TMR_CTRL_RESET;
			counter_low_byte       <= `TMR_BYTE_RESET;
			true_high              <= `TMR_BYTE_RESET;
			upper_byte_buffer      <= `TMR_BYTE_RESET;
			rdata                  <= `TMR_BYTE_RESET;
		end else begin
			if (ctrl_wr)
				timer_control_register <= wdata;
			counter_low_byte  <= next_low;
			true_high         <= next_high;
			upper_byte_buffer <= next_buf;
			rdata             <= next_rdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			inhibit       <= 2'h0;
			pre_cnt       <= '0;
			ext_prev      <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			ext_prev <= ext_sync;
			if (low_wr)
				inhibit <= `TMR_WR_INHIBIT;
			else if (inhibit != 2'h0)
				inhibit <= inhibit - 2'h1;
			if (low_wr | bypass)
				pre_cnt <= '0;
			else if (en & tick)
				pre_cnt <= pre_hit ? '0 : pre_cnt + PS_W'(1);
			// set beats a clear in the same cycle
			overflow_flag <= wrap | (overflow_flag & ~flag_clr);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	clk_count_a: assert property (
		(src == tmr_pkg::TMR_SRC_CLK) && en && bypass && mode8
		&& inhibit == 2'h0 && !low_wr && !ctrl_wr
		|=> counter_low_byte == $past(counter_low_byte) + 8'h01)
		else $error("timer mode did not count");

	prescale_hold_a: assert property (
		en && !bypass && pre_cnt != pre_mask && !low_wr
		|=> $stable(counter_low_byte))
		else $error("count moved inside prescale period");

	write_hold_a: assert property (
		low_wr |=> counter_low_byte == $past(wdata)
		##1 (low_wr || $stable(counter_low_byte))
		##1 (low_wr || $stable(counter_low_byte)))
		else $error("count moved during write inhibit");

	edge_only_a: assert property (
		(src == tmr_pkg::TMR_SRC_PIN) && !ext_event && !low_wr
		|=> $stable(counter_low_byte))
		else $error("counter moved without input edge");

	sync_lat_a: assert property (
		(src == tmr_pkg::TMR_SRC_PIN) && $past(nrst, 3)
		|-> ext_event == (edge_fall
		? ($past(external_count_input, 3)
		&& !$past(external_count_input, 2))
		: ($past(external_count_input, 2)
		&& !$past(external_count_input, 3))))
		else $error("edge not seen after sync delay");

	buf_only_a: assert property (
		high_wr && !low_wr && !low_max
		|=> $stable(true_high))
		else $error("buffer write reached true high byte");

	buf_capture_a: assert property (
		low_rd && !high_wr
		|=> upper_byte_buffer == $past(true_high)
		&& rdata == $past(counter_low_byte))
		else $error("low read did not capture high byte");

	buf_load_a: assert property (
		low_wr && !mode8
		|=> true_high == $past(upper_byte_buffer))
		else $error("low write did not load high byte");

	ovf_set_a: assert property (
		wrap |=> overflow_flag ##1 (overflow_flag || $past(flag_clr)))
		else $error("overflow flag not held");

	ovf_clear_a: assert property (
		flag_clr && !wrap |=> !overflow_flag)
		else $error("overflow flag not cleared");

	prescale_hit_a: assert property (
		en && !bypass && tick && pre_cnt == pre_mask
		&& inhibit == 2'h0 && !low_wr
		|=> counter_low_byte != $past(counter_low_byte))
		else $error("count missed end of prescale period");

	width8_a: assert property (
		mode8 |=> $stable(true_high))
		else $error("upper byte moved in 8-bit mode");

	wrap16_c: cover property (wrap && !mode8);
	wrap8_c: cover property (wrap && mode8);
	ext_count_c: cover property (ext_event && inc);
	read_pair_c: cover property (low_rd ##1 high_rd);

endmodule : tmr_counter

`default_nettype wire

// ===== timer0_counter_with_buffered_high_byte_tb.sv
`include "tmr_defs.svh"
`default_nettype none

module timer0_counter_with_buffered_high_byte_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// strobe order: ctrl_wr ctrl_rd low_wr low_rd high_wr high_rd clr
	// ----------------------------------------------------------------
	localparam logic [6:0] CW = 7'h40, CR = 7'h20, LW = 7'h10;
	localparam logic [6:0] LR = 7'h08, HW = 7'h04, HR = 7'h02;
	localparam logic [6:0] FC = 7'h01;

	logic               clk = 1'b0;
	logic               nrst = 1'b0;
	logic               pin = 1'b0;
	logic               ext = 1'b0;
	logic [6:0]         stb = 7'h00;
	tmr_pkg::tmr_byte_t wdata = 8'h00;
	tmr_pkg::tmr_byte_t rdata;
	logic               flag;
	tmr_pkg::tmr_byte_t ctrl_q;
	tmr_pkg::tmr_byte_t low_q;
	tmr_pkg::tmr_byte_t buf_q;
	logic               rd_seen = 1'b0;
	tmr_pkg::tmr_byte_t exp_q[$];
	tmr_pkg::tmr_byte_t e;
	int                 fail_count = 0;
	int                 checks = 0;
	logic [31:0]        seed = 32'h6b4e7cd1;
	int                 n;

	always #50 clk = ~clk;

	tmr_counter i_dut (
		.clk                    (clk),
		.nrst                   (nrst),
		.external_count_input   (ext),
		.ctrl_wr                (stb[6]),
		.ctrl_rd                (stb[5]),
		.low_wr                 (stb[4]),
		.low_rd                 (stb[3]),
		.high_wr                (stb[2]),
		.high_rd                (stb[1]),
		.wdata                  (wdata),
		.flag_clr               (stb[0]),
		.rdata                  (rdata),
		.timer_control_register (ctrl_q),
		.counter_low_byte       (low_q),
		.upper_byte_buffer      (buf_q),
		.overflow_flag          (flag)
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// one cycle per call, so idle calls count cycles exactly
	task automatic op(input logic [6:0] s, input tmr_pkg::tmr_byte_t d);
		@(posedge clk);
		stb <= s;
		wdata <= d;
		ext <= pin;
	endtask : op

	task automatic rd(input logic [6:0] s, input tmr_pkg::tmr_byte_t x);
		exp_q.push_back(x);
		op(s, 8'h00);
	endtask : rd

	task automatic chk_flag(input logic x);
		@(negedge clk);
		checks++;
		if (flag !== x) begin
			fail_count++;
			$display("CHECK FAILED overflow_flag exp %h got %h", x, flag);
		end
	endtask : chk_flag

	// all three register outputs at one falling edge, so no cycle is lost
	task automatic chk_regs(input tmr_pkg::tmr_byte_t c,
		input tmr_pkg::tmr_byte_t l, input tmr_pkg::tmr_byte_t b);
		@(negedge clk);
		checks += 3;
		if (ctrl_q !== c) begin
			fail_count++;
			$display("CHECK FAILED timer_control_register exp %h got %h",
				c, ctrl_q);
		end
		if (low_q !== l) begin
			fail_count++;
			$display("CHECK FAILED counter_low_byte exp %h got %h",
				l, low_q);
		end
		if (buf_q !== b) begin
			fail_count++;
			$display("CHECK FAILED upper_byte_buffer exp %h got %h",
				b, buf_q);
		end
	endtask : chk_regs

	// ----------------------------------------------------------------
	// monitor: read data stands from the taking edge, checked at the falling edge after it
	// ----------------------------------------------------------------
	always @(posedge clk) rd_seen <= stb[5] | stb[3] | stb[1];

	always @(negedge clk) begin
		if (rd_seen) begin
			e = exp_q.pop_front();
			checks++;
			if (rdata !== e) begin
				fail_count++;
				$display("CHECK FAILED rdata exp %h got %h", e, rdata);
			end
		end
	end

	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	initial begin
		#500000;
		fail_count++;
		results();
	end

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd(CR, `TMR_CTRL_RESET);
		rd(LR, 8'h00);
		rd(HR, 8'h00);
		// buffer write alone leaves the counter untouched
		op(HW, 8'ha5);
		op(LW, 8'h3c);
		op(HW, 8'h77);
		chk_regs(8'h08, 8'h3c, 8'ha5);
		rd(LR, 8'h3c);
		rd(HR, 8'ha5);
		// timer, bypass: two inhibited cycles, 16-bit wrap sets the flag
		op(CW, 8'h88);
		rd(CR, 8'h88);
		op(HW, 8'hff);
		op(LW, 8'hfc);
		repeat (9) op(7'h00, 8'h00);
		rd(LR, 8'h03);
		rd(HR, 8'h00);
		chk_flag(1'b1);
		// 8-bit wrap: upper byte frozen, flag sticky until cleared
		op(CW | FC, 8'h08);
		op(HW, 8'h55);
		op(LW, 8'hff);
		op(CW, 8'hc8);
		repeat (2) op(7'h00, 8'h00);
		rd(LR, 8'h00);
		rd(HR, 8'h55);
		chk_flag(1'b1);
		op(FC, 8'h00);
		op(7'h00, 8'h00);
		chk_flag(1'b0);
		// prescale ratio four, first period starts at enable
		op(CW, 8'h08);
		op(HW, 8'h00);
		op(LW, 8'h00);
		op(CW, 8'h81);
		repeat (8) op(7'h00, 8'h00);
		rd(LR, 8'h02);
		// pin counting, rising then falling edge select
		for (int k = 0; k < 2; k++) begin
			op(CW, 8'h08);
			op(HW, 8'h00);
			op(LW, 8'h00);
			op(CW, k ? 8'hb8 : 8'ha8);
			n = int'(rnd() % 32'hf) + 1;
			for (int i = 0; i < n; i++) begin
				pin = 1'b1;
				repeat (2) op(7'h00, 8'h00);
				pin = 1'b0;
				repeat (2) op(7'h00, 8'h00);
			end
			repeat (5) op(7'h00, 8'h00);
			chk_regs(k ? 8'hb8 : 8'ha8, 8'(n), 8'h00);
			rd(LR, 8'(n));
		end
		// let the last read's check run before the verdict
		repeat (2) op(7'h00, 8'h00);
		@(negedge clk);
		results();
	end
endmodule : timer0_counter_with_buffered_high_byte_tb

`default_nettype wire
